// *** logic/filter_port_pkg.sv ***
// Shared constants and carrier types for the parallel filter command port.
// Assumes a 250 MHz core clock.
package filter_port_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int SAMPLE_PERIOD_US = 50;
	localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;

	// ==========================================================
	// Command layout
	localparam int CMD_WIDTH = 8;
	localparam int FILTER_LSB = 0;
	localparam int FILTER_WIDTH = 4;
	localparam int HOLD_BIT = 4;
	localparam int NUM_FILTERS = 16;
	localparam int POS_WIDTH = 12;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [11:0] POS_RESET = 12'h000;
	localparam logic [2:0] SPECIAL_TOP = 3'h0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [11:0] in_pos;
		logic [11:0] out_pos;
	} galvo_pos_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT_TRIG = 3'b001,
		ST_MOVE_IN = 3'b010,
		ST_MOVE_OUT = 3'b011,
		ST_MOVE_BOTH = 3'b100
	} move_state_type;

endpackage

// *** logic/galvo_ramp.sv ***
// One galvanometer position ramp: steps toward a target one count per cycle.
// Assumes target is stable while moving.
`timescale 1ns/1ns
module galvo_ramp
	import filter_port_pkg::*;
#(
	parameter int WIDTH = POS_WIDTH
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic go_i,
	input wire logic [WIDTH-1:0] target_i,
	output logic [WIDTH-1:0] pos_o,
	output logic at_target_o
);

	// ==========================================================
	// Ramp.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pos_o <= '0;
		end else if (go_i && pos_o < target_i) begin
			pos_o <= pos_o + WIDTH'(1);
		end else if (go_i && pos_o > target_i) begin
			pos_o <= pos_o - WIDTH'(1);
		end
	end

	assign at_target_o = (pos_o == target_i);

endmodule

// *** logic/parallel_filter_command_port.sv ***
// Parallel command intake and filter change sequencer.
// Assumes CMD_I comes from pins and TRIGGER_I from a pin; both are synchronised here.
`timescale 1ns/1ns
// Notes on behaviour
// - Eight input lines form one byte, highest line is the MSB.
// - In online mode the byte is sampled every 50 us only; the code skips the sample while the sequencer is not idle.
// - A changed sample raises busy on the same edge that a filter command starts to run.
// - Every command is exactly one byte.
// - Bits 3..0 select filter, bit 4 holds for trigger; busy output drives host.
// - Without blanking, both galvanometers move together.
// - With blanking, input moves first, output follows after it arrives.
// - Blanking is a persistent setting and is reported as status.
// - Each filter keeps its own input and output position values, readable.
// - Commands 0 to 15 move immediately to that filter.
// - Commands 16 to 31 wait for a trigger, then move to value minus 16.
module parallel_filter_command_port
	import filter_port_pkg::*;
#(
	parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [CMD_WIDTH-1:0] CMD_I,
	input wire logic ONLINE_I,
	input wire logic TRIGGER_I,
	input wire logic BLANK_EN_I,
	input wire logic TABLE_WE_I,
	input wire logic [FILTER_WIDTH-1:0] TABLE_IDX_I,
	input wire filter_port_pkg::galvo_pos_type TABLE_WDATA_I,
	input wire logic [FILTER_WIDTH-1:0] RD_IDX_I,
	output filter_port_pkg::galvo_pos_type RD_DATA_O,
	output logic BUSY_O,
	output logic BLANK_STATUS_O,
	output filter_port_pkg::galvo_pos_type GALVO_O,
	output logic [FILTER_WIDTH-1:0] FILTER_O
);
	import filter_port_pkg::*;

	logic [CMD_WIDTH-1:0] cmd_s1_ff, cmd_s2_ff, last_cmd_ff;
	logic trig_s1_ff, trig_s2_ff, trig_d_ff;
	logic [31:0] tick_ff;
	logic blank_ff;
	galvo_pos_type table_ff [NUM_FILTERS];
	move_state_type state_ff;
	logic [FILTER_WIDTH-1:0] filt_ff;
	logic go_in, go_out, in_at, out_at;
	logic [POS_WIDTH-1:0] in_pos, out_pos;
	logic sample, changed, trig_edge, is_filter_cmd;

	// ==========================================================
	// Input synchronisers.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cmd_s1_ff <= CMD_RESET;
			cmd_s2_ff <= CMD_RESET;
			trig_s1_ff <= 1'b0;
			trig_s2_ff <= 1'b0;
			trig_d_ff <= 1'b0;
		end else begin
			cmd_s1_ff <= CMD_I;
			cmd_s2_ff <= cmd_s1_ff;
			trig_s1_ff <= TRIGGER_I;
			trig_s2_ff <= trig_s1_ff;
			trig_d_ff <= trig_s2_ff;
		end
	end
	assign trig_edge = trig_s2_ff && !trig_d_ff;

	// ==========================================================
	// Sample timer.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			tick_ff <= 32'h0;
		end else if (!ONLINE_I || tick_ff == 32'(SAMPLE_CYC - 1)) begin
			tick_ff <= 32'h0;
		end else begin
			tick_ff <= tick_ff + 32'h1;
		end
	end
	assign sample = ONLINE_I && (tick_ff == 32'(SAMPLE_CYC - 1)) && state_ff == ST_IDLE;
	assign changed = sample && (cmd_s2_ff != last_cmd_ff);
	assign is_filter_cmd = (cmd_s2_ff[CMD_WIDTH-1:HOLD_BIT+1] == SPECIAL_TOP);

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			last_cmd_ff <= CMD_RESET;
		end else if (sample) begin
			last_cmd_ff <= cmd_s2_ff;
		end
	end

	// ==========================================================
	// Blanking setting.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			blank_ff <= 1'b0;
		end else begin
			blank_ff <= BLANK_EN_I;
		end
	end
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			BLANK_STATUS_O <= 1'b0;
		end else begin
			BLANK_STATUS_O <= blank_ff;
		end
	end

	// ==========================================================
	// Position table.
	for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_table
		always_ff @(posedge CLK_I or negedge RST_N_I) begin
			if (!RST_N_I) begin
				table_ff[g] <= '{in_pos: POS_RESET, out_pos: POS_RESET};
			end else if (TABLE_WE_I && TABLE_IDX_I == FILTER_WIDTH'(g)) begin
				table_ff[g] <= TABLE_WDATA_I;
			end
		end
	end
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RD_DATA_O <= '0;
		end else begin
			RD_DATA_O <= table_ff[RD_IDX_I];
		end
	end

	// ==========================================================
	// Move sequencer.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_ff <= ST_IDLE;
			filt_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (changed && is_filter_cmd) begin
						filt_ff <= cmd_s2_ff[FILTER_LSB +: FILTER_WIDTH];
						if (cmd_s2_ff[HOLD_BIT]) begin
							state_ff <= ST_WAIT_TRIG;
						end else if (blank_ff) begin
							state_ff <= ST_MOVE_IN;
						end else begin
							state_ff <= ST_MOVE_BOTH;
						end
					end
				end
				ST_WAIT_TRIG: begin
					if (trig_edge) begin
						state_ff <= blank_ff ? ST_MOVE_IN : ST_MOVE_BOTH;
					end
				end
				ST_MOVE_IN: begin
					if (in_at) begin
						state_ff <= ST_MOVE_OUT;
					end
				end
				ST_MOVE_OUT: begin
					if (out_at) begin
						state_ff <= ST_IDLE;
					end
				end
				ST_MOVE_BOTH: begin
					if (in_at && out_at) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	assign go_in = (state_ff == ST_MOVE_IN) || (state_ff == ST_MOVE_BOTH);
	assign go_out = (state_ff == ST_MOVE_OUT) || (state_ff == ST_MOVE_BOTH);

	galvo_ramp #(.WIDTH(POS_WIDTH)) u_in_ramp (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.go_i(go_in),
		.target_i(table_ff[filt_ff].in_pos),
		.pos_o(in_pos),
		.at_target_o(in_at)
	);

	galvo_ramp #(.WIDTH(POS_WIDTH)) u_out_ramp (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.go_i(go_out),
		.target_i(table_ff[filt_ff].out_pos),
		.pos_o(out_pos),
		.at_target_o(out_at)
	);

	// ==========================================================
	// Outputs.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			BUSY_O <= 1'b0;
		end else if (changed) begin
			BUSY_O <= 1'b1;
		end else if (state_ff == ST_IDLE) begin
			BUSY_O <= 1'b0;
		end
	end
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			GALVO_O <= '0;
			FILTER_O <= '0;
		end else begin
			GALVO_O <= '{in_pos: in_pos, out_pos: out_pos};
			FILTER_O <= filt_ff;
		end
	end

	// ==========================================================
	// Checks.
	property p_busy_on_change;
		@(posedge CLK_I) disable iff (!RST_N_I) changed |=> BUSY_O;
	endproperty
	a_busy_on_change: assert property (p_busy_on_change) else $error("busy not raised");

	property p_no_sample_offline;
		@(posedge CLK_I) disable iff (!RST_N_I) !ONLINE_I |-> !sample ##1 tick_ff == 32'h0;
	endproperty
	a_no_sample_offline: assert property (p_no_sample_offline) else $error("sampled offline");

	property p_hold_waits;
		@(posedge CLK_I) disable iff (!RST_N_I) (changed && is_filter_cmd && cmd_s2_ff[HOLD_BIT]) |=> state_ff == ST_WAIT_TRIG;
	endproperty
	a_hold_waits: assert property (p_hold_waits) else $error("held command not waiting");

	property p_immediate;
		@(posedge CLK_I) disable iff (!RST_N_I) (changed && is_filter_cmd && !cmd_s2_ff[HOLD_BIT]) |=> (go_in && filt_ff == $past(cmd_s2_ff[3:0]));
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate move missing");

	property p_blank_out_still;
		@(posedge CLK_I) disable iff (!RST_N_I) state_ff == ST_MOVE_IN |-> !go_out;
	endproperty
	a_blank_out_still: assert property (p_blank_out_still) else $error("output moved early");

	sequence s_blank_start;
		changed && is_filter_cmd && !cmd_s2_ff[HOLD_BIT] && blank_ff;
	endsequence
	sequence s_in_alone;
		state_ff == ST_MOVE_IN && go_in && !go_out;
	endsequence
	property p_blank_order;
		@(posedge CLK_I) disable iff (!RST_N_I) s_blank_start |=> s_in_alone;
	endproperty
	a_blank_order: assert property (p_blank_order) else $error("blanked move not input first");

	property p_inphase;
		@(posedge CLK_I) disable iff (!RST_N_I) state_ff == ST_MOVE_BOTH |-> (go_in && go_out);
	endproperty
	a_inphase: assert property (p_inphase) else $error("not in phase");

	property p_busy_clear;
		@(posedge CLK_I) disable iff (!RST_N_I) (state_ff == ST_IDLE && !changed) |=> !BUSY_O;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy stuck");

	property p_blank_status;
		@(posedge CLK_I) disable iff (!RST_N_I) ##1 BLANK_STATUS_O == $past(blank_ff);
	endproperty
	a_blank_status: assert property (p_blank_status) else $error("blank status wrong");

	property p_table_read;
		@(posedge CLK_I) disable iff (!RST_N_I) ##1 RD_DATA_O == $past(table_ff[RD_IDX_I]);
	endproperty
	a_table_read: assert property (p_table_read) else $error("table read wrong");

endmodule

// *** tb/host_model.sv ***
// Host side of the parallel command port: a controller registering byte and trigger.
// Assumes the bench requests a byte and trigger level; both leave here on a clock edge.
`timescale 1ns/1ns
module host_model (
	input wire logic clk_i,
	input wire logic [7:0] cmd_i,
	input wire logic trig_i,
	output logic [7:0] cmd_o,
	output logic trig_o
);
	// =====
	// Only the parallel path exists here, and a command is one whole byte.
	always_ff @(posedge clk_i) begin
		cmd_o <= cmd_i;
		trig_o <= trig_i;
	end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the parallel filter command port.
// Assumes a host model in front of the command pins and a short sample period.
`timescale 1ns/1ns
module tb_top;
	import filter_port_pkg::*;
	localparam int SC = 20;
	logic clk = 0, rst_n = 0, online = 0, blank = 0, we = 0, trig = 0, trig_w, busy, bstat, ov, b;
	logic [7:0] cmd = 8'h00, cmd_w, c;
	logic [3:0] widx = 4'h0, ridx = 4'h0, filt, f;
	galvo_pos_type wdat = '0, rd, galvo, s;
	galvo_pos_type tbl [16];
	int fails = 0, tests_run = 0, seed = 32'h7aa7, r, i;
	host_model u_host (.clk_i(clk), .cmd_i(cmd), .trig_i(trig), .cmd_o(cmd_w), .trig_o(trig_w));
	parallel_filter_command_port #(.SAMPLE_CYC(SC)) u_dut (.CLK_I(clk), .RST_N_I(rst_n), .CMD_I(cmd_w),
		.ONLINE_I(online), .TRIGGER_I(trig_w), .BLANK_EN_I(blank), .TABLE_WE_I(we), .TABLE_IDX_I(widx),
		.TABLE_WDATA_I(wdat), .RD_IDX_I(ridx), .RD_DATA_O(rd), .BUSY_O(busy), .BLANK_STATUS_O(bstat),
		.GALVO_O(galvo), .FILTER_O(filt));
	initial forever #2 clk = ~clk;
	// =====
	task automatic chk(string n, logic [23:0] sn, logic [23:0] e);
		tests_run++;
		if (sn !== e) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", n, e, sn);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wait_busy(logic v);
		int k;
		for (k = 0; k < 3000 && busy !== v; k++) @(negedge clk);
		if (busy !== v) begin
			fails++;
			stop_test;
		end
	endtask
	task automatic quiet(int n, output logic bs);
		bs = 0;
		repeat (n) begin
			@(negedge clk);
			if (busy !== 1'b0) bs = 1;
		end
	endtask
	// Sends one command, optionally triggers it, and notes any cycle where both mirrors step together.
	task automatic move(logic [7:0] cm, output logic o);
		galvo_pos_type p;
		int k;
		o = 0;
		p = galvo;
		@(posedge clk) cmd <= cm;
		wait_busy(1);
		if (cm[4]) begin
			repeat (3 * SC) @(negedge clk);
			chk("held galvo", galvo, p);
			@(posedge clk) trig <= 1;
			repeat (4) @(posedge clk);
			trig <= 0;
		end
		for (k = 0; k < 3000 && busy === 1'b1; k++) begin
			@(negedge clk);
			if (galvo.in_pos !== p.in_pos && galvo.out_pos !== p.out_pos) o = 1;
			p = galvo;
		end
		chk("busy end", busy, 0);
		chk("galvo", galvo, tbl[cm[3:0]]);
		chk("filter", filt, cm[3:0]);
	endtask
	// =====
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		stop_test;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		@(negedge clk);
		chk("reset busy", busy, 0);
		chk("reset galvo", galvo, 0);
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			tbl[i] = {4'h0, i[3:0], 1'b0, r[2:0], 4'h0, ~i[3:0], 1'b0, r[5:3]};
			@(posedge clk);
			we <= 1;
			widx <= i[3:0];
			wdat <= tbl[i];
		end
		@(posedge clk) we <= 0;
		for (i = 0; i < 16; i++) begin
			@(posedge clk) ridx <= i[3:0];
			@(posedge clk);
			@(negedge clk) chk("readback", rd, tbl[i]);
		end
		$display("test table done");
		@(posedge clk) online <= 1;
		f = 4'h0;
		for (i = 0; i < 6; i++) begin
			r = $random(seed);
			if (i == 5) begin
				f = (f == 4'hf) ? 4'h0 : 4'hf;
			end else begin
				f = f + 4'h1 + 4'($unsigned(r) % 14);
			end
			@(posedge clk) blank <= i[0];
			repeat (3) @(negedge clk);
			chk("blank status", bstat, i[0]);
			move({4'h0, f}, ov);
			chk("in phase", ov, !i[0]);
		end
		$display("test moves done");
		@(posedge clk) cmd <= {4'h0, f};
		quiet(3 * SC, b);
		chk("same byte", b, 0);
		c = {4'h1, f + 4'h5};
		move(c, ov);
		f = c[3:0];
		$display("test hold done");
		@(posedge clk) online <= 0;
		cmd <= {4'h0, f + 4'h3};
		quiet(3 * SC, b);
		chk("offline", b, 0);
		@(posedge clk) online <= 1;
		move({4'h0, f + 4'h3}, ov);
		f = f + 4'h3;
		$display("test offline done");
		s = tbl[f];
		@(posedge clk) cmd <= 8'h40;
		quiet(3 * SC, b);
		chk("special busy", b, 1);
		chk("special busy end", busy, 0);
		chk("special filter", filt, f);
		chk("special galvo", galvo, s);
		$display("test special done");
		stop_test;
	end
endmodule
